// ==== hdlc_tx_assertions.sv ====
// Port assertions of the transmit HDLC controller
`timescale 1ns/1ps
`include "hdlc_tx_map.svh"
module hdlc_tx_checker (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire hdlc_tx_pkg::bus_req_type bus_i,
   input wire logic [7:0] rdata_o,
   input wire logic t1_mode_i,
   input wire logic init_done_i,
   input wire hdlc_tx_pkg::line_slot_type slot_i,
   input wire logic tx_bit_o,
   input wire logic tx_claim_o
);
   logic [7:0] sup_ff;
   logic map_ff, en_ff, boc_ff, ovh_ff, wr1, rd1, rds, sup_hit, boc_on;
   logic [5:0] age_ff;
   assign wr1 = bus_i.wr && bus_i.addr == `HT_CTL1_OFF;
   assign rd1 = bus_i.rd && bus_i.addr == `HT_CTL1_OFF;
   assign rds = bus_i.rd && bus_i.addr == `HT_SUP_OFF;
   assign sup_hit = sup_ff[slot_i.bitpos];
   assign boc_on = boc_ff && t1_mode_i;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sup_ff <= 8'h00;
         map_ff <= 1'b0;
         en_ff <= 1'b0;
         boc_ff <= 1'b0;
         ovh_ff <= 1'b0;
         age_ff <= 6'h3F;
      end else begin
         if (bus_i.wr && bus_i.addr == `HT_SUP_OFF) sup_ff <= bus_i.wdata;
         if (wr1) map_ff <= bus_i.wdata[`HT_C1_MAP];
         if (bus_i.wr && bus_i.addr == `HT_CTL2_OFF) begin
            en_ff <= bus_i.wdata[`HT_C2_EN];
            boc_ff <= bus_i.wdata[`HT_C2_CODE_SEND];
         end
         if (bus_i.wr && bus_i.addr == `HT_OVH_OFF) ovh_ff <= bus_i.wdata[`HT_OVH_EN];
         // Age of the soft reset; saturates when done or cut short
         if (init_done_i) age_ff <= 6'h3F;
         else if (wr1 && bus_i.wdata[`HT_C1_RST]) age_ff <= 6'h00;
         else if (age_ff != 6'h3F) age_ff <= age_ff + 6'h01;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   claim_tick_a: assert property (tx_claim_o |-> $past(slot_i.tick))
      else $error("claim without a slot tick");
   claim_enabled_a: assert property (
      tx_claim_o && !$past(slot_i.ovh) |-> $past(en_ff)) else $error("claim while disabled");
   suppress_bit_a: assert property (
      tx_claim_o && !$past(slot_i.ovh) |-> !$past(sup_hit)) else $error("suppressed bit used");
   payload_map_a: assert property (
      tx_claim_o && !$past(map_ff) && !$past(boc_on) |-> !$past(slot_i.ovh))
      else $error("overhead bit used in channel mode");
   overhead_map_a: assert property (
      tx_claim_o && $past(map_ff) && !$past(boc_on) |-> $past(slot_i.ovh) && $past(ovh_ff))
      else $error("payload bit used in overhead mode");
   reset_clears_a: assert property (
      $past(rd1) && $past(age_ff) > 6'h2C |-> !rdata_o[`HT_C1_RST])
      else $error("controller reset bit stuck");
   reset_active_a: assert property (
      $past(rd1) && $past(age_ff) < 6'h1E |-> rdata_o[`HT_C1_RST])
      else $error("controller reset bit cleared early");
   suppress_read_a: assert property (
      $past(rds) |-> rdata_o == $past(sup_ff)) else $error("suppress readback wrong");
endmodule : hdlc_tx_checker
bind hdlc_tx_controller hdlc_tx_checker chk_u (.clk_i(clk_i), .arst_n_i(arst_n_i),
   .bus_i(bus_i), .rdata_o(rdata_o), .t1_mode_i(t1_mode_i), .init_done_i(init_done_i),
   .slot_i(slot_i), .tx_bit_o(tx_bit_o), .tx_claim_o(tx_claim_o));

// ==== hdlc_tx_controller.sv ====
// Transmit HDLC controller: register port, transmit FIFO, framer and line bit mapper
`timescale 1ns/1ps
`include "hdlc_tx_map.svh"

module hdlc_tx_controller (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire hdlc_tx_pkg::bus_req_type bus_i,
   output logic [7:0] rdata_o,
   input wire logic t1_mode_i,
   input wire logic init_done_i,
   input wire hdlc_tx_pkg::line_slot_type slot_i,
   output logic tx_bit_o,
   output logic tx_claim_o
);

   hdlc_tx_pkg::state_type s_ff;
   hdlc_tx_pkg::state_type nxt_s;

   hdlc_tx_pkg::tx_state_type eff;
   hdlc_tx_pkg::fifo_ent_type ent;
   logic in_rst;
   logic avail;
   logic full;
   logic wr_fifo;
   logic abt_edge;
   logic ovh_ok;
   logic chan_ok;
   logic tick_boc;
   logic tick_hdlc;
   logic stuff_now;
   logic cur_bit;
   logic cur_stf;
   logic cur_crc;
   logic fb;
   logic [7:0] byte_v;
   logic [7:0] fill_v;
   logic [15:0] boc_pat;
   logic [`HT_PTR_W-1:0] used;
   logic [`HT_PTR_W-1:0] rd_inc;

   always_comb begin
      nxt_s = s_ff;
      eff = s_ff.st;
      ent = s_ff.mem[s_ff.rd[`HT_PTR_W-2:0]];
      byte_v = `HT_FLAG;
      cur_bit = 1'b0;
      cur_stf = 1'b0;
      cur_crc = 1'b0;
      fb = 1'b0;
      rd_inc = s_ff.rd + `HT_PTR_W'(1);
      in_rst = s_ff.ctl1[`HT_C1_RST];
      avail = (s_ff.wr != s_ff.rd);

      // A message set to loop keeps its bytes until the loop ends
      used = s_ff.wr - (s_ff.ctl1[`HT_C1_LOOP] ? s_ff.ms : s_ff.rd);
      full = (used >= `HT_PTR_W'(`HT_FIFO_DEPTH));
      wr_fifo = bus_i.wr && (bus_i.addr == `HT_FIFO_OFF) && !full && !in_rst;
      // Only a rising edge of the abort bit acts
      abt_edge = bus_i.wr && (bus_i.addr == `HT_CTL2_OFF) && bus_i.wdata[`HT_C2_ABT]
         && !s_ff.ctl2[`HT_C2_ABT];

      fill_v = s_ff.ctl1[`HT_C1_FS] ? `HT_ONES : `HT_FLAG;
      boc_pat = {`HT_ONES, 1'b0, s_ff.boc, 1'b0};

      nxt_s.claim = 1'b0;

      // Controller reset sequence; a new host write below still wins
      if (in_rst) begin
         nxt_s.rd = s_ff.wr;
         nxt_s.ms = s_ff.wr;
         nxt_s.st = hdlc_tx_pkg::ST_IDLE;
         nxt_s.bitcnt = 4'h0;
         nxt_s.stf = 1'b0;
         nxt_s.crcb = 1'b0;
         nxt_s.ones = 3'h0;
         nxt_s.extra = 1'b0;
         nxt_s.abt_pend = 1'b1;
         nxt_s.chan = s_ff.ctl2[4:0];
         if (s_ff.rst_cnt != 8'h00) begin
            nxt_s.rst_cnt = s_ff.rst_cnt - 8'h01;
         end
         if (s_ff.rst_cnt <= 8'h01) begin
            nxt_s.ctl1[`HT_C1_RST] = 1'b0;
         end
      end
      if (init_done_i) begin
         nxt_s.ctl1[`HT_C1_RST] = 1'b0;
      end

      // Register writes
      if (bus_i.wr) begin
         case (bus_i.addr)
            `HT_CTL1_OFF: begin
               // Writing 0 does not cut a running controller reset short
               nxt_s.ctl1 = bus_i.wdata | (nxt_s.ctl1 & (8'h01 << `HT_C1_RST));
               if (bus_i.wdata[`HT_C1_RST] && !in_rst) begin
                  nxt_s.rst_cnt = 8'(`HT_RST_CYCLES);
               end
            end
            `HT_SUP_OFF: begin
               nxt_s.sup = bus_i.wdata;
            end
            `HT_CTL2_OFF: begin
               nxt_s.ctl2 = bus_i.wdata;
            end
            `HT_BOC_OFF: begin
               nxt_s.boc = bus_i.wdata[5:0];
            end
            `HT_OVH_OFF: begin
               nxt_s.ovh_en = bus_i.wdata[`HT_OVH_EN];
            end
            default: begin
            end
         endcase
      end

      // FIFO write: a byte written with EOM carries the end mark; while LOOP is set every byte carries both marks
      if (wr_fifo) begin
         nxt_s.mem[s_ff.wr[`HT_PTR_W-2:0]] = {s_ff.ctl1[`HT_C1_LOOP],
            s_ff.ctl1[`HT_C1_EOM] | s_ff.ctl1[`HT_C1_LOOP], bus_i.wdata};
         nxt_s.wr = s_ff.wr + `HT_PTR_W'(1);
         nxt_s.ctl1[`HT_C1_EOM] = 1'b0;
      end

      // Register reads, data in the following cycle
      nxt_s.rdata = 8'h00;
      if (bus_i.rd) begin
         case (bus_i.addr)
            `HT_CTL1_OFF: nxt_s.rdata = s_ff.ctl1;
            `HT_SUP_OFF: nxt_s.rdata = s_ff.sup;
            `HT_CTL2_OFF: nxt_s.rdata = s_ff.ctl2;
            `HT_BOC_OFF: nxt_s.rdata = {2'h0, s_ff.boc};
            `HT_OVH_OFF: nxt_s.rdata = {s_ff.ovh_en, 7'h00};
            `HT_STAT_OFF: nxt_s.rdata = {4'h0, s_ff.st != hdlc_tx_pkg::ST_IDLE, in_rst,
               full, !avail};
            default: nxt_s.rdata = 8'h00;
         endcase
      end

      // Bit slot selection
      ovh_ok = slot_i.ovh && s_ff.ovh_en;
      chan_ok = !slot_i.ovh && (slot_i.chan == s_ff.chan) && !s_ff.sup[slot_i.bitpos];
      tick_boc = slot_i.tick && slot_i.ovh && t1_mode_i && s_ff.ctl2[`HT_C2_CODE_SEND];
      tick_hdlc = slot_i.tick && s_ff.ctl2[`HT_C2_EN] && !in_rst && !tick_boc
         && (s_ff.ctl1[`HT_C1_MAP] ? ovh_ok : chan_ok);

      // Bit-oriented code: 0, six code bits, 0, eight ones, repeated
      if (tick_boc) begin
         nxt_s.bit_o = boc_pat[s_ff.boc_cnt];
         nxt_s.boc_cnt = s_ff.boc_cnt + 4'h1;
         nxt_s.claim = 1'b1;
      end

      // The stuffed zero may fall after the last bit of a byte, before the next byte
      stuff_now = s_ff.stf && (s_ff.ones == `HT_STUFF_RUN);

      if (tick_hdlc) begin
         nxt_s.claim = 1'b1;
         if (stuff_now) begin
            cur_bit = 1'b0;
            nxt_s.ones = 3'h0;
         end else begin
            if (s_ff.bitcnt == 4'h0) begin
               // Next byte choice at a byte boundary
               // A waiting message shares the closing flag as its opening flag
               if (s_ff.st == hdlc_tx_pkg::ST_GAP && !s_ff.extra && avail) begin
                  eff = hdlc_tx_pkg::ST_DATA;
               end
               case (eff)
                  hdlc_tx_pkg::ST_IDLE: begin
                     if (s_ff.abt_pend) begin
                        byte_v = `HT_ABORT;
                        nxt_s.abt_pend = 1'b0;
                     end else if (avail) begin
                        byte_v = `HT_FLAG;
                        nxt_s.crc = `HT_CRC_INIT;
                        nxt_s.st = hdlc_tx_pkg::ST_DATA;
                     end else begin
                        byte_v = fill_v;
                     end
                  end
                  hdlc_tx_pkg::ST_DATA: begin
                     if (!avail) begin
                        // Underrun ends the frame with an abort
                        byte_v = `HT_ABORT;
                        nxt_s.st = hdlc_tx_pkg::ST_IDLE;
                     end else begin
                        byte_v = ent.data;
                        cur_stf = !s_ff.ctl1[`HT_C1_NO_STUFF];
                        cur_crc = 1'b1;
                        nxt_s.st = hdlc_tx_pkg::ST_DATA;
                        nxt_s.rd = rd_inc;
                        if (ent.eom) begin
                           nxt_s.st = s_ff.ctl1[`HT_C1_CRCD] ? hdlc_tx_pkg::ST_CLOSE
                              : hdlc_tx_pkg::ST_CRC_LO;
                           // Rewind only while no newer byte follows the looped message
                           if (ent.loop && s_ff.ctl1[`HT_C1_LOOP] && (s_ff.wr == rd_inc)) begin
                              nxt_s.rd = s_ff.ms;
                           end else begin
                              nxt_s.ms = rd_inc;
                           end
                        end
                     end
                  end
                  hdlc_tx_pkg::ST_CRC_LO: begin
                     byte_v = ~s_ff.crc[7:0];
                     cur_stf = !s_ff.ctl1[`HT_C1_NO_STUFF];
                     nxt_s.st = hdlc_tx_pkg::ST_CRC_HI;
                  end
                  hdlc_tx_pkg::ST_CRC_HI: begin
                     byte_v = ~s_ff.crc[15:8];
                     cur_stf = !s_ff.ctl1[`HT_C1_NO_STUFF];
                     nxt_s.st = hdlc_tx_pkg::ST_CLOSE;
                  end
                  hdlc_tx_pkg::ST_CLOSE: begin
                     byte_v = `HT_FLAG;
                     nxt_s.crc = `HT_CRC_INIT;
                     nxt_s.extra = s_ff.ctl1[`HT_C1_TWO_FLAGS];
                     nxt_s.st = hdlc_tx_pkg::ST_GAP;
                  end
                  hdlc_tx_pkg::ST_GAP: begin
                     if (s_ff.extra) begin
                        byte_v = `HT_FLAG;
                        nxt_s.extra = 1'b0;
                     end else begin
                        byte_v = fill_v;
                        nxt_s.st = hdlc_tx_pkg::ST_IDLE;
                     end
                  end
                  default: begin
                     byte_v = fill_v;
                     nxt_s.st = hdlc_tx_pkg::ST_IDLE;
                  end
               endcase
               cur_bit = byte_v[0];
               nxt_s.sh = {1'b0, byte_v[7:1]};
               nxt_s.bitcnt = 4'h7;
               nxt_s.stf = cur_stf;
               nxt_s.crcb = cur_crc;
            end else begin
               cur_stf = s_ff.stf;
               cur_crc = s_ff.crcb;
               cur_bit = s_ff.sh[0];
               nxt_s.sh = {1'b0, s_ff.sh[7:1]};
               nxt_s.bitcnt = s_ff.bitcnt - 4'h1;
            end

            // Ones run counts only inside stuffable bytes
            if (cur_stf && cur_bit) begin
               nxt_s.ones = s_ff.ones + 3'h1;
            end else begin
               nxt_s.ones = 3'h0;
            end

            // Frame check over data bits, least significant bit first
            if (cur_crc) begin
               fb = s_ff.crc[0] ^ cur_bit;
               nxt_s.crc = {1'b0, s_ff.crc[15:1]} ^ (fb ? `HT_CRC_POLY : 16'h0000);
            end
         end
         nxt_s.bit_o = cur_bit;
      end

      // An abort outranks the next state chosen on the same tick; the byte in flight, even one chosen on that tick, still finishes
      if (abt_edge) begin
         nxt_s.rd = s_ff.wr;
         nxt_s.ms = s_ff.wr;
         nxt_s.abt_pend = 1'b1;
         nxt_s.st = hdlc_tx_pkg::ST_IDLE;
         nxt_s.extra = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign rdata_o = s_ff.rdata;
   assign tx_bit_o = s_ff.bit_o;
   assign tx_claim_o = s_ff.claim;

endmodule : hdlc_tx_controller

// ==== hdlc_tx_map.svh ====
// Register map, field positions, codes and timing of the transmit HDLC controller
`ifndef HDLC_TX_MAP_SVH
`define HDLC_TX_MAP_SVH

`define HT_ADDR_W 10
`define HT_CTL1_OFF 10'h110
`define HT_SUP_OFF 10'h111
`define HT_FIFO_OFF 10'h112
`define HT_CTL2_OFF 10'h113
`define HT_BOC_OFF 10'h116
`define HT_OVH_OFF 10'h117
`define HT_STAT_OFF 10'h11C
`define HT_REG_RST 8'h00

`define HT_C1_TWO_FLAGS 7
`define HT_C1_LOOP 6
`define HT_C1_RST 5
`define HT_C1_MAP 4
`define HT_C1_FS 3
`define HT_C1_EOM 2
`define HT_C1_NO_STUFF 1
`define HT_C1_CRCD 0
`define HT_C2_ABT 7
`define HT_C2_CODE_SEND 6
`define HT_C2_EN 5
`define HT_OVH_EN 7

`define HT_FIFO_DEPTH 64
`define HT_PTR_W 7
`define HT_FLAG 8'h7E
`define HT_ONES 8'hFF
`define HT_ABORT 8'hFE
`define HT_CRC_POLY 16'h8408
`define HT_CRC_INIT 16'hFFFF
`define HT_STUFF_RUN 3'h5

`define HT_CLK_PERIOD_NS 25
`define HT_RST_TIME_NS 1000
`define HT_RST_CYCLES ((`HT_RST_TIME_NS) / (`HT_CLK_PERIOD_NS))

`endif

// ==== hdlc_tx_pkg.sv ====
// Types of the transmit HDLC controller
package hdlc_tx_pkg;
`include "hdlc_tx_map.svh"

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_DATA = 3'h1,
      ST_CRC_LO = 3'h3,
      ST_CRC_HI = 3'h2,
      ST_CLOSE = 3'h6,
      ST_GAP = 3'h7
   } tx_state_type;

   typedef struct packed {
      logic [`HT_ADDR_W-1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bus_req_type;

   typedef struct packed {
      logic tick;
      logic ovh;
      logic [4:0] chan;
      logic [2:0] bitpos;
   } line_slot_type;

   typedef struct packed {
      logic loop;
      logic eom;
      logic [7:0] data;
   } fifo_ent_type;

   typedef struct packed {
      fifo_ent_type [`HT_FIFO_DEPTH-1:0] mem;
      logic [7:0] ctl1;
      logic [7:0] sup;
      logic [7:0] ctl2;
      logic [5:0] boc;
      logic ovh_en;
      logic [7:0] rdata;
      logic [`HT_PTR_W-1:0] wr;
      logic [`HT_PTR_W-1:0] rd;
      logic [`HT_PTR_W-1:0] ms;
      tx_state_type st;
      logic [7:0] sh;
      logic [3:0] bitcnt;
      logic stf;
      logic crcb;
      logic [2:0] ones;
      logic [15:0] crc;
      logic extra;
      logic abt_pend;
      logic [7:0] rst_cnt;
      logic [4:0] chan;
      logic [3:0] boc_cnt;
      logic bit_o;
      logic claim;
   } state_type;

endpackage : hdlc_tx_pkg

// ==== line_slot_src.sv ====
// Line stream source: one bit slot every other cycle, four channels then an overhead bit
`timescale 1ns/1ps
module line_slot_src (
   input wire logic clk_i,
   input wire logic arst_n_i,
   output hdlc_tx_pkg::line_slot_type slot_o
);
   logic [5:0] cnt_ff;
   logic ph_ff;
   hdlc_tx_pkg::line_slot_type s;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_ff <= 6'h00;
         ph_ff <= 1'b0;
      end else begin
         ph_ff <= ~ph_ff;
         if (ph_ff) cnt_ff <= (cnt_ff == 6'h20) ? 6'h00 : cnt_ff + 6'h01;
      end
   end
   always_comb begin
      s.tick = ph_ff;
      s.ovh = (cnt_ff == 6'h20);
      s.chan = {3'h0, cnt_ff[4:3]};
      s.bitpos = ~cnt_ff[2:0];
      // Fields are scrambled between ticks so stale values cannot pass
      slot_o = ph_ff ? s : {1'b0, ~s[8:0]};
   end
endmodule : line_slot_src

// ==== testbench.sv ====
// Self-checking testbench of the transmit HDLC controller
`timescale 1ns/1ps
`include "hdlc_tx_map.svh"
module testbench;
   typedef struct packed {logic [9:0] a; logic [7:0] d; logic [7:0] e;} reg_row_type;
   typedef struct packed {logic [7:0] c; logic [7:0] s; logic [7:0] d;} frm_row_type;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   hdlc_tx_pkg::bus_req_type bus = '0;
   hdlc_tx_pkg::line_slot_type slot;
   logic [7:0] rdata;
   logic t1_mode = 1'b0;
   logic init_done = 1'b0;
   logic tx_bit, tx_claim, p_ovh;
   logic [4:0] p_chan;
   logic [7:0] exp_chan = 8'h00;
   logic [15:0] crc;
   bit ovh_only;
   bit cap[$];
   bit ex[$];
   int mismatches, tests_run, ones;
   reg_row_type regs[6] = '{'{10'h111, 8'h5A, 8'h5A}, '{10'h113, 8'h22, 8'h22},
      '{10'h110, 8'h09, 8'h09}, '{10'h100, 8'h55, 8'h00}, '{10'h111, 8'h00, 8'h00},
      '{10'h117, 8'h80, 8'h80}};
   frm_row_type frms[8] = '{'{8'h09, 8'h00, 8'h01}, '{8'h89, 8'h00, 8'h3C},
      '{8'h08, 8'h00, 8'hA5}, '{8'h0B, 8'h00, 8'hFF}, '{8'h09, 8'h00, 8'hFF},
      '{8'h09, 8'h0F, 8'h81}, '{8'h49, 8'h00, 8'h3C}, '{8'h09, 8'h00, 8'h66}};
   always #12.5 clk_i = ~clk_i;
   line_slot_src src_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .slot_o(slot));
   hdlc_tx_controller dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus_i(bus), .rdata_o(rdata),
      .t1_mode_i(t1_mode), .init_done_i(init_done), .slot_i(slot), .tx_bit_o(tx_bit),
      .tx_claim_o(tx_claim));
   always @(posedge clk_i) begin
      if (tx_claim === 1'b1 && p_ovh == ovh_only) begin
         cap.push_back(tx_bit);
         if (!p_ovh) chk8("channel", exp_chan, {3'h0, p_chan});
      end
      p_ovh <= slot.tick & slot.ovh;
      p_chan <= slot.chan;
   end
   task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk8
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk_i);
      bus <= '0;
      @(posedge clk_i);
   endtask : wr
   task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
      logic [7:0] d;
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk_i);
      bus <= '0;
      #1 d = rdata;
      chk8($sformatf("register %h", a), e, d);
      @(posedge clk_i);
   endtask : rd_chk
   task automatic put_byte(input logic [7:0] v, input bit stuff, input bit fold);
      for (int i = 0; i < 8; i++) begin
         ex.push_back(v[i]);
         if (fold) crc = (crc[0] ^ v[i]) ? (crc >> 1) ^ `HT_CRC_POLY : crc >> 1;
         ones = v[i] ? ones + 1 : 0;
         if (stuff && ones == 5) begin
            ex.push_back(1'b0);
            ones = 0;
         end
      end
   endtask : put_byte
   function automatic bit found();
      bit m;
      for (int i = 0; i + ex.size() <= cap.size(); i++) begin
         m = 1'b1;
         foreach (ex[j]) if (cap[i + j] != ex[j]) m = 1'b0;
         if (m) return 1'b1;
      end
      return 1'b0;
   endfunction : found
   task automatic wait_bits();
      for (int g = 0; g < 9000 && cap.size() < ex.size() + 80; g++) @(posedge clk_i);
   endtask : wait_bits
   task automatic abort_chk(input bit want);
      ex.delete();
      put_byte(`HT_ABORT, 1'b0, 1'b0);
      put_byte(8'hFF, 1'b0, 1'b0);
      wait_bits();
      chk8("abort pattern", {7'h00, want}, {7'h00, found()});
   endtask : abort_chk
   task automatic send_frame(input frm_row_type r);
      wr(`HT_SUP_OFF, r.s);
      wr(`HT_CTL1_OFF, r.c | 8'h04);
      cap.delete();
      wr(`HT_FIFO_OFF, r.d);
      ex.delete();
      put_byte(`HT_FLAG, 1'b0, 1'b0);
      for (int k = 0; k <= int'(r.c[6]); k++) begin
         crc = `HT_CRC_INIT;
         put_byte(r.d, !r.c[1], 1'b1);
         crc = ~crc;
         if (!r.c[0]) put_byte(crc[7:0], !r.c[1], 1'b0);
         if (!r.c[0]) put_byte(crc[15:8], !r.c[1], 1'b0);
         put_byte(`HT_FLAG, 1'b0, 1'b0);
      end
      if (r.c[7]) put_byte(`HT_FLAG, 1'b0, 1'b0);
      if (!r.c[6]) put_byte(8'hFF, 1'b0, 1'b0);
      wait_bits();
      chk8("frame", 8'h01, {7'h00, found()});
   endtask : send_frame
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (40000) @(posedge clk_i);
      mismatches++;
      give_verdict();
   end
   initial begin
      repeat (3) @(posedge clk_i);
      arst_n_i <= 1'b1;
      @(posedge clk_i);
      foreach (regs[i]) begin
         wr(regs[i].a, regs[i].d);
         rd_chk(regs[i].a, regs[i].e);
      end
      cap.delete();
      wr(`HT_CTL1_OFF, 8'h28);
      rd_chk(`HT_CTL1_OFF, 8'h28);
      rd_chk(`HT_STAT_OFF, 8'h05);
      exp_chan = 8'h02;
      repeat (`HT_RST_CYCLES + 4) @(posedge clk_i);
      rd_chk(`HT_CTL1_OFF, 8'h08);
      abort_chk(1'b1);
      foreach (frms[i]) send_frame(frms[i]);
      // Channel field changes here without a controller reset
      cap.delete();
      wr(`HT_CTL2_OFF, 8'hA3);
      abort_chk(1'b1);
      cap.delete();
      wr(`HT_CTL2_OFF, 8'hA3);
      abort_chk(1'b0);
      wr(`HT_CTL2_OFF, 8'h23);
      cap.delete();
      wr(`HT_CTL2_OFF, 8'hA3);
      abort_chk(1'b1);
      wr(`HT_CTL1_OFF, 8'h18);
      repeat (300) @(posedge clk_i);
      wr(`HT_CTL1_OFF, 8'h08);
      wr(`HT_BOC_OFF, 8'h15);
      t1_mode <= 1'b1;
      ovh_only = 1'b1;
      cap.delete();
      wr(`HT_CTL2_OFF, 8'h63);
      ex = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
      put_byte(8'hFF, 1'b0, 1'b0);
      wait_bits();
      chk8("code pattern", 8'h01, {7'h00, found()});
      t1_mode <= 1'b0;
      ovh_only = 1'b0;
      arst_n_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      arst_n_i <= 1'b1;
      @(posedge clk_i);
      foreach (regs[i]) rd_chk(regs[i].a, 8'h00);
      rd_chk(`HT_STAT_OFF, 8'h01);
      init_done <= 1'b1;
      wr(`HT_CTL1_OFF, 8'h20);
      rd_chk(`HT_CTL1_OFF, 8'h00);
      give_verdict();
   end
endmodule : testbench
